//--- pkg/lsh_map.svh
// Constant map for the local bus status and hold arbiter
`ifndef LSH_MAP_SVH
`define LSH_MAP_SVH
// Cycle status codes, bit 2 is the MSB
`define LSH_ST_INTA 3'h0
`define LSH_ST_IORD 3'h1
`define LSH_ST_IOWR 3'h2
`define LSH_ST_HALT 3'h3
`define LSH_ST_FETCH 3'h4
`define LSH_ST_MEMRD 3'h5
`define LSH_ST_MEMWR 3'h6
`define LSH_ST_PASSIVE 3'h7
// Width of the memory address
`define LSH_AW 20
// Last start-up count, at which the select pins are judged
`define LSH_ARM_LAST 2'h3
`define LSH_ARM_ONE 2'h1
// Reset values of outputs
`define LSH_INACTIVE 1'b1
`define LSH_ZERO 1'b0
`endif

//--- pkg/lsh_pkg.sv
// Types shared by the local bus status and hold arbiter
`include "lsh_map.svh"
package lsh_pkg;
	// Bus sequencing phases
	typedef enum logic [2:0] {
		LSH_IDLE, LSH_T1, LSH_T2, LSH_T3, LSH_T4, LSH_HOLD
	} lsh_phase_t;
	// One bus cycle request from the core
	typedef struct packed {
		logic valid;
		logic [2:0] code;
		logic [`LSH_AW-1:0] addr;
		logic refresh;
	} lsh_req_t;
	// Whole state of the arbiter
	typedef struct packed {
		lsh_phase_t phase;
		lsh_req_t cur;
		logic [2:0] holdSync;
		logic [2:0] ucsSync;
		logic [2:0] lcsSync;
		logic holdSeen;
		logic [1:0] armCnt;
		logic armed;
		logic testFloat;
		logic lockPend;
		logic lockOn;
		logic grant;
		logic busFloat;
		logic [2:0] status;
		logic ucsN;
		logic lcsN;
		logic rfshN;
	} lsh_state_t;
endpackage

//--- logic/lsh_bus_ctrl.sv
// Local bus status encoder, lock, hold arbiter and memory selects
// Function
// [R01] No other master takes bus while locked
// [R02] Lock asserts at first locked data cycle
// [R03] Lock held until instruction completes
// [R04] No prefetch while lock asserted
// [R05] Lock floats in hold and reset
// [R06] Drive three-bit cycle status code
// [R07] Passive code seven when idle
// [R08] Master holds request high while needed
// [R09] Raise grant in answer to request
// [R10] Float bus with grant, same cycle
// [R11] Drop grant test_float_mode request seen low
// [R12] Drive bus again at next cycle
// [R13] Enhanced: drop grant for pending refresh
// [R14] Master yields bus when grant drops
// [R15] Upper select for upper block references
// [R16] Upper select driven during hold
// [R17] Both selects low at reset: test float
// [R18] Test float floats every pin
// [R19] Lower select sampled, driven in hold
// [R20] Refresh indicator low in enhanced refresh
// [R21] Finish cycle, never grant while locked
`timescale 1ns/100ps
`include "lsh_map.svh"
module lsh_bus_ctrl
	import lsh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire lsh_req_t cycReq,
	output logic cycReady,
	input wire logic lockPrefix,
	input wire logic instrDone,
	input wire logic enhancedMode,
	input wire logic [`LSH_AW-1:0] upperMask,
	input wire logic [`LSH_AW-1:0] lowerMask,
	input wire logic holdReqIn,
	output logic holdGrantOut,
	output logic holdGrantOeN,
	output logic [2:0] cycStatusOut,
	output logic cycStatusOeN,
	output logic lockOut_n,
	output logic lockOeN,
	output logic refreshCycleOut_n,
	output logic refreshOeN,
	output logic upperMemSelectOut_n,
	input wire logic upperMemSelectIn_n,
	output logic upperMemSelectOeN,
	output logic lowerMemSelectOut_n,
	input wire logic lowerMemSelectIn_n,
	output logic lowerMemSelectOeN,
	output logic busOeN,
	output logic testFloatMode
);
	lsh_state_t q; // Registered state
	lsh_state_t d; // Next state
	logic allFloat; // Start-up or test float
	logic takeHold; // Hold seen and no lock, so hold may be granted
	logic isFetch; // Requested cycle is a prefetch
	logic refreshPend; // Enhanced refresh waiting

	// Memory cycle types drive the chip selects
	function automatic logic isMem(input logic [2:0] code);
		isMem = (code == `LSH_ST_FETCH) || (code == `LSH_ST_MEMRD) ||
			(code == `LSH_ST_MEMWR);
	endfunction

	// Helper terms for the idle decision
	always_comb begin
		allFloat = q.armed || q.testFloat;
		isFetch = cycReq.code == `LSH_ST_FETCH;
		refreshPend = cycReq.valid && cycReq.refresh && enhancedMode;
		// [R21] No grant locked
		takeHold = q.holdSeen && !q.lockOn;
		// [R04] Prefetch held off
		cycReady = (q.phase == LSH_IDLE) && !allFloat && !takeHold &&
			!(isFetch && q.lockOn);
	end

	// Next state of the whole block
	always_comb begin
		d = q;
		// Three-stage sample of the hold request and both select pins
		d.holdSync = {q.holdSync[1:0], holdReqIn};
		d.ucsSync = {q.ucsSync[1:0], upperMemSelectIn_n};
		d.lcsSync = {q.lcsSync[1:0], lowerMemSelectIn_n};
		// Change counts test_float_mode second and third agree
		if (q.holdSync[1] == q.holdSync[2]) begin
			d.holdSeen = q.holdSync[2];
		end
		// Start-up window after reset release
		if (q.armed) begin
			d.armCnt = q.armCnt + `LSH_ARM_ONE;
			if (q.armCnt == `LSH_ARM_LAST) begin
				d.armed = `LSH_ZERO;
				// [R17] Both selects low
				d.testFloat = !q.ucsSync[1] && !q.ucsSync[2] &&
					!q.lcsSync[1] && !q.lcsSync[2];
			end
		end
		// Lock prefix seen, wait for a data cycle
		if (lockPrefix) begin
			d.lockPend = `LSH_INACTIVE;
		end
		// [R03] Release at completion
		if (instrDone && q.lockOn) begin
			d.lockOn = `LSH_ZERO;
		end
		unique case (q.phase)
			// Idle: grant hold, or start a cycle
			LSH_IDLE: begin
				if (allFloat) begin
					d.phase = LSH_IDLE;
				end else if (takeHold) begin
					// [R09] Grant hold
					d.grant = `LSH_INACTIVE;
					// [R10] Float with grant
					d.busFloat = `LSH_INACTIVE;
					d.phase = LSH_HOLD;
				end else if (cycReq.valid && cycReady) begin
					d.phase = LSH_T1;
					d.cur = cycReq;
					// [R12] Drive again on need
					d.busFloat = `LSH_ZERO;
					// [R06] Drive status code
					d.status = cycReq.code;
					// [R02] Lock at data cycle
					if (q.lockPend && !isFetch) begin
						d.lockOn = `LSH_INACTIVE;
						// Prefix in this same cycle stays pending
						d.lockPend = lockPrefix;
					end
					// [R15] Upper block select
					d.ucsN = !(isMem(cycReq.code) &&
						((cycReq.addr | upperMask) == '1));
					// [R19] Lower block select
					d.lcsN = !(isMem(cycReq.code) &&
						((cycReq.addr & ~lowerMask) == '0));
					// [R20] Refresh indicator
					d.rfshN = !(cycReq.refresh && enhancedMode);
				end
			end
			// Address phase
			LSH_T1: begin
				d.phase = LSH_T2;
			end
			// Data phase
			LSH_T2: begin
				d.phase = LSH_T3;
			end
			// Status goes passive before the end
			LSH_T3: begin
				d.phase = LSH_T4;
				// [R07] Passive code
				d.status = `LSH_ST_PASSIVE;
			end
			// [R21] Cycle completes
			LSH_T4: begin
				d.phase = LSH_IDLE;
				d.ucsN = `LSH_INACTIVE;
				d.lcsN = `LSH_INACTIVE;
				d.rfshN = `LSH_INACTIVE;
			end
			// Bus owned by the external master
			LSH_HOLD: begin
				if (!q.holdSeen) begin
					// [R11] Drop grant
					d.grant = `LSH_ZERO;
					d.phase = LSH_IDLE;
				end else if (refreshPend) begin
					// [R13] Ask bus back
					d.grant = `LSH_ZERO;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q.phase <= LSH_IDLE;
			q.cur <= '0;
			q.holdSync <= '0;
			q.ucsSync <= '0;
			q.lcsSync <= '0;
			q.holdSeen <= `LSH_ZERO;
			q.armCnt <= '0;
			q.armed <= `LSH_INACTIVE;
			q.testFloat <= `LSH_ZERO;
			q.lockPend <= `LSH_ZERO;
			q.lockOn <= `LSH_ZERO;
			q.grant <= `LSH_ZERO;
			q.busFloat <= `LSH_INACTIVE;
			q.status <= `LSH_ST_PASSIVE;
			q.ucsN <= `LSH_INACTIVE;
			q.lcsN <= `LSH_INACTIVE;
			q.rfshN <= `LSH_INACTIVE;
		end else begin
			q <= d;
		end
	end

	// Pin drivers, enables low while driving
	always_comb begin
		holdGrantOut = q.grant;
		cycStatusOut = q.status;
		// [R01] Lock guards bus
		lockOut_n = !q.lockOn;
		refreshCycleOut_n = q.rfshN;
		upperMemSelectOut_n = q.ucsN;
		lowerMemSelectOut_n = q.lcsN;
		testFloatMode = q.testFloat;
		// [R18] Float all pins
		holdGrantOeN = allFloat;
		// [R16] Upper select driven
		upperMemSelectOeN = allFloat;
		// [R19] Lower select driven
		lowerMemSelectOeN = allFloat;
		// [R05] Lock floats
		lockOeN = allFloat || q.busFloat;
		cycStatusOeN = allFloat || q.busFloat;
		refreshOeN = allFloat || q.busFloat;
		busOeN = allFloat || q.busFloat;
	end
endmodule

//--- testbench/lsh_bus_chk.sv
// Checker for the bus status and hold arbiter
`timescale 1ns/100ps
module lsh_bus_chk
	import lsh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire lsh_req_t cycReq,
	input wire logic cycReady,
	input wire logic enhancedMode,
	input wire logic holdReqIn,
	input wire logic holdGrantOut,
	input wire logic [2:0] cycStatusOut,
	input wire logic cycStatusOeN,
	input wire logic lockOut_n,
	input wire logic lockOeN,
	input wire logic refreshOeN,
	input wire logic holdGrantOeN,
	input wire logic upperMemSelectOeN,
	input wire logic lowerMemSelectOeN,
	input wire logic busOeN,
	input wire logic testFloatMode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [2:0] codeQ; // Code of last taken request
	wire logic take = cycReq.valid && cycReady;
	// Keep the code for the walk
	always_ff @(posedge clk_sys) begin
		if (take)
			codeQ <= cycReq.code;
	end
	sequence s_walk;
		(cycStatusOut == codeQ) [*3] ##1 cycStatusOut == 3'h7;
	endsequence
	a_status_walk: assert property (take |=> s_walk)
		else $error("status walk wrong");
	a_grant_float: assert property ($rose(holdGrantOut) |->
		busOeN && lockOeN && cycStatusOeN && refreshOeN)
		else $error("bus not floated");
	a_lock_float: assert property (holdGrantOut |-> lockOeN)
		else $error("lock driven in hold");
	a_fetch_locked: assert property (!lockOut_n && !lockOeN |->
		!(take && cycReq.code == 3'h4)) else $error("fetch while locked");
	a_grant_unlocked: assert property ($rose(holdGrantOut) |->
		$past(lockOut_n)) else $error("grant while locked");
	a_grant_drop: assert property (!holdReqIn [*8] |-> !holdGrantOut)
		else $error("grant kept");
	a_sel_hold: assert property (holdGrantOut |->
		!upperMemSelectOeN && !lowerMemSelectOeN) else $error("sel float");
	a_float_all: assert property (testFloatMode |->
		busOeN && lockOeN && cycStatusOeN && refreshOeN && holdGrantOeN &&
		upperMemSelectOeN && lowerMemSelectOeN) else $error("pin driven");
	a_refresh_yield: assert property (enhancedMode && holdGrantOut &&
		cycReq.valid && cycReq.refresh |-> ##[1:4] !holdGrantOut)
		else $error("no yield");
endmodule

//--- testbench/lsh_far_master.sv
// Far master that borrows the local bus
`timescale 1ns/100ps
module lsh_far_master (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic want,
	input wire logic grant,
	output logic holdReq
);
	logic grantQ; // Grant at last edge
	logic yieldQ; // Bus handed back
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			grantQ <= 1'b0;
			yieldQ <= 1'b0;
		end else begin
			grantQ <= grant;
			yieldQ <= want && (yieldQ || (grantQ && !grant));
		end
	end
	assign holdReq = want && !yieldQ;
endmodule

//--- testbench/lsh_bus_ctrl_tb.sv
// Testbench for the bus status and hold arbiter
`timescale 1ns/100ps
module lsh_bus_ctrl_tb
	import lsh_pkg::*;
;
	logic clk_sys = 0, rst = 1, lockPrefix = 0, instrDone = 0;
	logic enhancedMode = 0, want = 0, upPin = 1, loPin = 1;
	logic [19:0] upperMask = 20'h003ff, lowerMask = 20'h003ff;
	lsh_req_t cycReq = '0;
	logic cycReady, holdReqIn, holdGrantOut, holdGrantOeN, cycStatusOeN;
	logic [2:0] cycStatusOut;
	logic lockOut_n, lockOeN, refreshCycleOut_n, refreshOeN, busOeN;
	logic upperMemSelectOut_n, upperMemSelectOeN, lowerMemSelectOut_n;
	logic lowerMemSelectOeN, testFloatMode;
	int error_cnt = 0, checks_done = 0, cycles = 0;
	// Pin levels seen by the select inputs
	wire logic upperMemSelectIn_n =
		upperMemSelectOeN ? upPin : upperMemSelectOut_n;
	wire logic lowerMemSelectIn_n =
		lowerMemSelectOeN ? loPin : lowerMemSelectOut_n;
	lsh_bus_ctrl dut (.*);
	lsh_far_master far (.clk_sys, .rst, .want, .grant(holdGrantOut),
		.holdReq(holdReqIn));
	always #25 clk_sys = ~clk_sys;
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, logic [3:0] e, logic [3:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic resetDut(logic pin);
		@(posedge clk_sys);
		rst <= 1'b1;
		upPin <= pin;
		loPin <= pin;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask
	// Request a cycle; returns in T1
	task automatic runCyc(logic [2:0] c, logic [19:0] a, logic rf);
		int n;
		n = 0;
		@(posedge clk_sys);
		cycReq <= {1'b1, c, a, rf};
		@(negedge clk_sys);
		while (!cycReady && n < 60) begin
			n++;
			@(negedge clk_sys);
		end
		// Ready never came: count it
		if (!cycReady) begin
			error_cnt++;
			$display("MISMATCH cycReady exp 1 got 0");
		end
		@(posedge clk_sys);
		cycReq <= '0;
		#1;
	endtask
	task automatic waitG(logic v);
		int n;
		n = 0;
		while (holdGrantOut !== v && n < 40) begin
			n++;
			@(negedge clk_sys);
		end
		// Grant never settled: count it
		if (holdGrantOut !== v) begin
			error_cnt++;
			$display("MISMATCH holdGrantOut exp %h got %h", v, holdGrantOut);
		end
	endtask
	task automatic t_codes;
		for (int c = 0; c < 7; c++) begin
			runCyc(c[2:0], 20'hfffff, 1'b1);
			chk("status", c[3:0], cycStatusOut);
			chk("upper", {3'h0, c < 4}, upperMemSelectOut_n);
			chk("noRefresh", 4'h1, refreshCycleOut_n);
			repeat (3) @(posedge clk_sys);
			#1 chk("passive", 4'h7, cycStatusOut);
		end
	endtask
	task automatic t_lock;
		@(posedge clk_sys);
		lockPrefix <= 1'b1;
		@(posedge clk_sys);
		lockPrefix <= 1'b0;
		runCyc(3'h5, 20'h00000, 1'b0);
		chk("lock", 4'h0, lockOut_n);
		chk("lower", 4'h0, lowerMemSelectOut_n);
		repeat (4) @(posedge clk_sys);
		cycReq <= {1'b1, 3'h4, 20'h0, 1'b0};
		@(negedge clk_sys);
		chk("fetchReady", 4'h0, cycReady);
		chk("lockHeld", 4'h0, lockOut_n);
		@(posedge clk_sys);
		cycReq <= '0;
		instrDone <= 1'b1;
		@(posedge clk_sys);
		instrDone <= 1'b0;
		#1 chk("unlock", 4'h1, lockOut_n);
	endtask
	task automatic t_hold;
		@(posedge clk_sys);
		want <= 1'b1;
		waitG(1'b1);
		chk("grant", 4'h1, holdGrantOut);
		chk("busFloat", 4'h1, busOeN);
		@(posedge clk_sys);
		want <= 1'b0;
		waitG(1'b0);
		chk("grantLow", 4'h0, holdGrantOut);
		chk("busIdle", 4'h1, busOeN);
		runCyc(3'h1, 20'h0, 1'b0);
		chk("busDrive", 4'h0, busOeN);
	endtask
	task automatic t_refresh;
		@(posedge clk_sys);
		enhancedMode <= 1'b1;
		want <= 1'b1;
		waitG(1'b1);
		runCyc(3'h5, 20'h00400, 1'b1);
		chk("refresh", 4'h0, refreshCycleOut_n);
		@(posedge clk_sys);
		want <= 1'b0;
		enhancedMode <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic t_float;
		resetDut(1'b0);
		chk("float", 4'h1, testFloatMode);
		chk("floatBus", 4'h1, busOeN);
		resetDut(1'b1);
		chk("normal", 4'h0, testFloatMode);
	endtask
	initial begin
		resetDut(1'b1);
		t_codes();
		t_lock();
		t_hold();
		t_refresh();
		t_float();
		tally_and_finish();
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
endmodule
bind lsh_bus_ctrl lsh_bus_chk chk (.*);
